/* core/etcc_pkg.sv */
// Purpose: Shared constants for the elapsed time capture counter
// Assumes: Timebase clock is the selected synthesizer VCO
// Notes: Widths and reset values live here
`default_nettype none
package etcc_pkg;
	localparam int CNT_W = 40;
	localparam int DIV_THIRD = 8;
	localparam int DIV_SECOND = 20;
	localparam int PRE_W = 5;
	localparam int FUNC_W = 6;
	localparam logic [FUNC_W-1:0] TRIG_FUNC_CODE = 6'h27;
	localparam int NUM_BYTES = 5;
	localparam int IDX_W = 3;
	localparam int CFG_W = 8;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h01;
	localparam logic [CNT_W-1:0] COUNT_RST = 40'h00_0000_0000;
	localparam logic ARMED_RST = 1'b1;
	localparam logic SPI_MODE_RST = 1'b1;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	localparam logic SEL_THIRD = 1'b0;
	localparam logic SRC_PIN = 1'b1;
endpackage
`default_nettype wire

/* core/etcc_top.sv */
// Purpose: Free-running 40-bit timestamp counter with edge capture
// Assumes: vco_clk_i is the synthesizer VCO chosen by vco_select_o
// Notes: Capture taken in the VCO domain, handed to clk_i by handshake
// What the document requires
// RQ1 - 40-bit counter counts up and wraps
// RQ2 - Capture on trigger pin or chip-select fall
// RQ3 - Pin edge polarity follows invert setting
// RQ4 - Timebase is VCO divided by 8 or 20
// RQ5 - Select 0 third synthesizer, 1 second
// RQ6 - Source bit 1 pin, 0 chip select
// RQ7 - Enable low holds counter at zero
// RQ8 - Chip-select fall captures count while armed
// RQ9 - High byte read locks until low byte read
// RQ10 - Capture and re-arm within one burst
// RQ11 - Function code 0x27 makes pin a trigger
// RQ12 - Pin capture locks until low byte read
// RQ13 - Host reads low byte to re-arm
// RQ14 - Captured count readable as five bytes
// RQ15 - Host keeps trigger high 10 ns
// RQ16 - Host waits 1 us before next trigger
// RQ17 - Capture at the chip-select edge itself; code sees the edge two VCO cycles late
// RQ18 - Select also steers reference detectors VCO
// RQ19 - Host toggles enable before starting trigger
// RQ20 - Clear low for normal counting
// RQ21 - Clear high holds counter at zero
// RQ22 - Edges synchronized, value crosses stably
// RQ23 - Strap pin chooses serial interface at reset
`default_nettype none
module etcc_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic vco_clk_i,
	input wire logic counter_run_enable_i,
	input wire logic count_clear_i,
	input wire logic timebase_vco_select_i,
	input wire logic trigger_source_select_i,
	input wire logic [etcc_pkg::FUNC_W-1:0] pin_function_code_i,
	input wire logic pin_polarity_invert_i,
	input wire logic trig_pin_i,
	input wire logic serial_chip_select_n_i,
	input wire logic msb_read_i,
	input wire logic lsb_read_i,
	input wire logic [etcc_pkg::IDX_W-1:0] byte_index_i,
	input wire logic strap_pin_i,
	output logic [etcc_pkg::CNT_W-1:0] captured_count_o,
	output logic [7:0] count_byte_o,
	output logic capture_armed_o,
	output logic capture_pulse_o,
	output logic vco_select_o,
	output logic spi_mode_o
);
	import etcc_pkg::*;

	// Host-domain state
	logic [CFG_W-1:0] cfg_src_q;
	logic armed_q;
	logic [CNT_W-1:0] captured_q;
	logic [7:0] byte_q;
	logic pulse_q;
	logic req_meta_q, req_s_q, req_d_q;
	logic new_cap;
	logic strap_meta_q, strap_s_q;
	logic [1:0] strap_cnt_q;
	logic spi_mode_q;
	logic sel_q;

	// VCO-domain state
	logic [CFG_W-1:0] cfg_meta_q, cfg_q;
	logic pin_meta_q, pin_s_q, pin_d_q;
	logic scs_meta_q, scs_s_q, scs_d_q;
	logic ack_meta_q, ack_s_q;
	logic [PRE_W-1:0] pre_q;
	logic [PRE_W-1:0] pre_lim;
	logic tick;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] hold_q;
	logic req_q;
	logic lock_q;
	logic busy, fire, pin_edge, scs_edge;
	logic v_ce, v_en, v_clr, v_sel, v_src, v_func, v_pol, v_arm;

	assign new_cap = req_s_q ^ req_d_q;

	// Registered first so the synchronizer never sees combinational glitches
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_src_q <= CFG_RST;
		end else begin
			cfg_src_q <= {ce_i, counter_run_enable_i, count_clear_i, timebase_vco_select_i,
				trigger_source_select_i, pin_function_code_i == TRIG_FUNC_CODE, // [RQ11]
				pin_polarity_invert_i, armed_q};
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sel_q <= SEL_THIRD;
		end else if (ce_i) begin
			sel_q <= timebase_vco_select_i; // [RQ18]
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			req_meta_q <= 1'b0;
			req_s_q <= 1'b0;
			req_d_q <= 1'b0;
		end else if (ce_i) begin
			req_meta_q <= req_q; // [RQ22]
			req_s_q <= req_meta_q;
			req_d_q <= req_s_q;
		end
	end

	// hold_q is steady while the request toggle is outstanding
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			captured_q <= COUNT_RST;
			pulse_q <= 1'b0;
		end else if (ce_i) begin
			pulse_q <= new_cap;
			if (new_cap) begin
				captured_q <= hold_q; // [RQ22]
			end
		end
	end

	// Pin capture beats re-arm in the same cycle so no event is lost
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			armed_q <= ARMED_RST;
		end else if (ce_i) begin
			if (new_cap && trigger_source_select_i == SRC_PIN) begin
				armed_q <= 1'b0; // [RQ12]
			end else if (lsb_read_i) begin
				armed_q <= 1'b1; // [RQ9] [RQ10] [RQ12]
			end else if (msb_read_i && trigger_source_select_i != SRC_PIN) begin
				armed_q <= 1'b0; // [RQ9]
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			byte_q <= 8'h00;
		end else if (ce_i) begin
			if (byte_index_i < IDX_W'(NUM_BYTES)) begin
				byte_q <= captured_q[8*byte_index_i +: 8]; // [RQ14]
			end else begin
				byte_q <= 8'h00;
			end
		end
	end

	// Strap caught a few cycles after release, once synchronized
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			strap_meta_q <= 1'b0;
			strap_s_q <= 1'b0;
			strap_cnt_q <= 2'h0;
			spi_mode_q <= SPI_MODE_RST;
		end else begin
			strap_meta_q <= strap_pin_i;
			strap_s_q <= strap_meta_q;
			if (strap_cnt_q != STRAP_WAIT + 2'h1) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
			if (strap_cnt_q == STRAP_WAIT) begin
				spi_mode_q <= strap_s_q; // [RQ23]
			end
		end
	end

	assign captured_count_o = captured_q;
	assign count_byte_o = byte_q;
	assign capture_armed_o = armed_q;
	assign capture_pulse_o = pulse_q;
	assign vco_select_o = sel_q;
	assign spi_mode_o = spi_mode_q;

	// VCO domain: synchronizers keep running even when frozen
	always_ff @(posedge vco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cfg_meta_q <= CFG_RST;
			cfg_q <= CFG_RST;
			pin_meta_q <= 1'b0;
			pin_s_q <= 1'b0;
			scs_meta_q <= 1'b1;
			scs_s_q <= 1'b1;
			ack_meta_q <= 1'b0;
			ack_s_q <= 1'b0;
		end else begin
			cfg_meta_q <= cfg_src_q; // [RQ22]
			cfg_q <= cfg_meta_q;
			pin_meta_q <= trig_pin_i;
			pin_s_q <= pin_meta_q;
			scs_meta_q <= serial_chip_select_n_i;
			scs_s_q <= scs_meta_q;
			ack_meta_q <= req_d_q;
			ack_s_q <= ack_meta_q;
		end
	end

	assign {v_ce, v_en, v_clr, v_sel, v_src, v_func, v_pol, v_arm} = cfg_q;
	assign pre_lim = (v_sel == SEL_THIRD) ? PRE_W'(DIV_THIRD - 1) : PRE_W'(DIV_SECOND - 1); // [RQ5]
	assign tick = (pre_q == pre_lim);
	assign busy = req_q ^ ack_s_q;
	assign pin_edge = ((pin_s_q ^ v_pol) && !(pin_d_q ^ v_pol)); // [RQ3]
	assign scs_edge = scs_d_q && !scs_s_q;
	// Edge is seen two VCO cycles late; the count is taken then
	assign fire = v_arm && v_en && !busy && !lock_q &&
		(v_src == SRC_PIN ? (v_func && pin_edge) : scs_edge); // [RQ2] [RQ6] [RQ8] [RQ17]

	always_ff @(posedge vco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_d_q <= 1'b0;
			scs_d_q <= 1'b1;
		end else if (v_ce) begin
			pin_d_q <= pin_s_q;
			scs_d_q <= scs_s_q;
		end
	end

	always_ff @(posedge vco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pre_q <= '0;
		end else if (v_ce) begin
			if (tick || pre_q > pre_lim) begin
				pre_q <= '0; // [RQ4]
			end else begin
				pre_q <= pre_q + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge vco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= COUNT_RST;
		end else if (v_ce) begin
			if (!v_en || v_clr) begin
				count_q <= COUNT_RST; // [RQ7] [RQ20] [RQ21]
			end else if (tick) begin
				count_q <= count_q + CNT_W'(1); // [RQ1]
			end
		end
	end

	// Local lock bridges the gap until the host-side disarm arrives
	always_ff @(posedge vco_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold_q <= COUNT_RST;
			req_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (v_ce) begin
			if (fire) begin
				hold_q <= count_q; // [RQ8] [RQ11]
				req_q <= ~req_q;
			end
			if (fire && v_src == SRC_PIN) begin
				lock_q <= 1'b1; // [RQ12]
			end else if (!v_arm || v_src != SRC_PIN) begin
				lock_q <= 1'b0;
			end
		end
	end

	// Host-domain checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	a_capture_loads_value: assert property (ce_i && new_cap |=> captured_q == $past(hold_q)) // [RQ22]
		else $error("captured value not loaded");
	a_capture_holds: assert property (!(ce_i && new_cap) |=> $stable(captured_q)) // [RQ12]
		else $error("captured value changed without capture");
	a_pin_disarm: assert property (ce_i && new_cap && trigger_source_select_i |=> !armed_q) // [RQ12]
		else $error("pin capture did not disarm");
	a_lsb_rearms: assert property (ce_i && lsb_read_i && !new_cap |=> armed_q) // [RQ9]
		else $error("low byte read did not re-arm");
	a_msb_locks: assert property (ce_i && msb_read_i && !lsb_read_i && !trigger_source_select_i
		|=> !armed_q) // [RQ9]
		else $error("high byte read did not lock");
	a_byte_zero: assert property (ce_i && byte_index_i == 3'h0 ##1 ce_i && $stable(captured_q)
		|-> count_byte_o == captured_q[7:0]) // [RQ14]
		else $error("low byte readback wrong");
	a_freeze_arm: assert property (!ce_i |=> $stable(armed_q) && $stable(count_byte_o)) // [RQ9]
		else $error("state moved with clock enable low");
	a_select_out: assert property (ce_i |=> vco_select_o == $past(timebase_vco_select_i)) // [RQ18]
		else $error("vco select not forwarded");
	a_pulse_marks: assert property ($changed(captured_q) |-> capture_pulse_o) // [RQ22]
		else $error("pulse check");

	// VCO-domain checks
	a_count_held: assert property (@(posedge vco_clk_i) disable iff (reset_i)
		v_ce && (!v_en || v_clr) |=> count_q == COUNT_RST) // [RQ7] [RQ21]
		else $error("counter not held at zero");
	a_count_steps: assert property (@(posedge vco_clk_i) disable iff (reset_i)
		v_ce && v_en && !v_clr && tick |=> count_q == $past(count_q) + CNT_W'(1)) // [RQ1]
		else $error("counter did not step on tick");
	a_prescale_range: assert property (@(posedge vco_clk_i) disable iff (reset_i)
		v_ce && $stable(v_sel) && pre_q <= pre_lim |=> pre_q <= $past(pre_lim)) // [RQ4]
		else $error("prescaler past its limit");
endmodule
`default_nettype wire

/* tb/etcc_host_model.sv */
// Purpose: Host side trigger pin driver and free VCO source
// Assumes: Bench asks for one trigger at a time
// Notes: Pulse is far wider than the minimum so the synchronizer sees it
`default_nettype none
module etcc_host_model (
	input wire logic fire_i,
	input wire logic idle_i,
	output logic trig_pin_o,
	output logic vco_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	assign trig_pin_o = busy ^ idle_i;
	initial begin
		vco_clk_o = 1'b0;
		#3.1;
		forever #62.5 vco_clk_o = ~vco_clk_o;
	end
	always @(posedge fire_i) begin
		busy = 1'b1;
		#500; // Active level held well over 10 ns
		busy = 1'b0;
		#1000; // Guard after the pulse ends before next trigger
	end
endmodule
`default_nettype wire

/* tb/etcc_top_bench.sv */
// Purpose: Directed checks of capture, lock, re-arm and timebase
// Assumes: Strap high at first reset and low at the last one, VCO runs free
// Notes: Counts are checked as spans, synchronizer delay is fuzzy
`default_nettype none
module etcc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import etcc_pkg::*;
	logic clk, rst, en, clr, sel, src, pol, cs_n, msb, lsb, fire, trig, vco, ce, strap;
	logic [5:0] code;
	logic [2:0] idx;
	logic [39:0] cap;
	logic [7:0] byte_o;
	logic armed, pulse, vsel, spi;
	int num_errors = 0;
	int n_tests = 0;
	etcc_host_model host (.fire_i(fire), .idle_i(pol), .trig_pin_o(trig), .vco_clk_o(vco));
	etcc_top dut (.clk_i(clk), .reset_i(rst), .ce_i(ce), .vco_clk_i(vco),
		.counter_run_enable_i(en), .count_clear_i(clr), .timebase_vco_select_i(sel),
		.trigger_source_select_i(src), .pin_function_code_i(code),
		.pin_polarity_invert_i(pol), .trig_pin_i(trig), .serial_chip_select_n_i(cs_n),
		.msb_read_i(msb), .lsb_read_i(lsb), .byte_index_i(idx), .strap_pin_i(strap),
		.captured_count_o(cap), .count_byte_o(byte_o), .capture_armed_o(armed),
		.capture_pulse_o(pulse), .vco_select_o(vsel), .spi_mode_o(spi));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic finish_test();
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Bounded wait, a lost pulse shows up as a failed compare
	task automatic wait_cap(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 200 && !seen; i++) begin
			@(negedge clk);
			if (pulse === 1'b1) seen = 1'b1;
		end
	endtask
	task automatic cs_fall(input logic e);
		logic seen;
		cs_n = 1'b0;
		wait_cap(seen);
		cs_n = 1'b1;
		chk("cs capture", e, seen);
		if (e && !seen) finish_test();
		tick(50);
	endtask
	task automatic pin_fire(input logic e);
		logic seen;
		fire = 1'b1;
		wait_cap(seen);
		fire = 1'b0;
		chk("pin capture", e, seen);
		if (e && !seen) finish_test();
		tick(250);
	endtask
	task automatic rd(input logic top);
		if (top) msb = 1'b1;
		else lsb = 1'b1;
		tick(1);
		msb = 1'b0;
		lsb = 1'b0;
		tick(1);
	endtask
	// Two captures 20 us apart, span must match the divided VCO rate
	task automatic meas();
		logic [39:0] a, d;
		time t1, t2, per, mid;
		per = sel ? 125 * 20 : 125 * 8;
		t1 = $time;
		cs_fall(1'b1);
		a = cap;
		rd(1'b0);
		tick(2500);
		t2 = $time;
		cs_fall(1'b1);
		d = cap - a;
		// Each capture lags its edge by two to three VCO cycles, so round
		mid = (t2 - t1 + per / 2) / per;
		chk("span", 1'b1, d + 1 >= mid && d <= mid + 1);
		rd(1'b0);
	endtask
	initial begin
		rst = 1'b1; en = 1'b0; clr = 1'b0; sel = 1'b0; src = 1'b0; pol = 1'b0;
		cs_n = 1'b1; msb = 1'b0; lsb = 1'b0; fire = 1'b0; code = 6'h00; idx = 3'h0;
		ce = 1'b1;
		strap = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(4);
		chk("spi mode", 1'b1, spi);
		chk("armed", 1'b1, armed);
		cs_fall(1'b0);
		chk("held zero", 40'h00_0000_0000, cap);
		rd(1'b0);
		en = 1'b1;
		tick(20);
		meas();
		cs_fall(1'b1);
		for (int i = 0; i < 6; i++) begin
			idx = 3'(i);
			tick(2);
			chk("byte", i < 5 ? 40'(cap[8*(i%5)+:8]) : 40'h0, 40'(byte_o));
		end
		rd(1'b1);
		chk("locked", 1'b0, armed);
		cs_fall(1'b0);
		rd(1'b0);
		chk("rearmed", 1'b1, armed);
		cs_fall(1'b1);
		src = SRC_PIN;
		code = 6'h26;
		tick(20);
		rd(1'b0);
		pin_fire(1'b0);
		code = TRIG_FUNC_CODE;
		tick(20);
		pin_fire(1'b1);
		pin_fire(1'b0);
		pol = 1'b1;
		tick(20);
		rd(1'b0);
		cs_fall(1'b0);
		pin_fire(1'b1);
		src = 1'b0;
		sel = 1'b1;
		tick(20);
		rd(1'b0);
		chk("vco select", 1'b1, vsel);
		en = 1'b0;
		tick(40);
		en = 1'b1;
		tick(40);
		cs_fall(1'b1);
		chk("restart", 1'b1, cap <= 40'h00_0000_0001);
		ce = 1'b0;
		rd(1'b1);
		ce = 1'b1;
		chk("frozen", 1'b1, armed);
		clr = 1'b1;
		tick(20);
		cs_fall(1'b1);
		chk("cleared", 40'h00_0000_0000, cap);
		rd(1'b0);
		clr = 1'b0;
		tick(20);
		meas();
		strap = 1'b0;
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(4);
		chk("two wire", 1'b0, spi);
		chk("reset armed", 1'b1, armed);
		chk("reset cap", 40'h00_0000_0000, cap);
		finish_test();
	end
endmodule
`default_nettype wire
